// ===== src/gmoc_pkg.sv
// Constants for the global mode and output-enable configuration block.
// Assumes an APB master with 32-bit data; all register fields live in one word.
package gmoc_pkg;
	localparam logic [11:0] GOC_OFFSET = 12'h008;
	localparam int QUAD_BIT = 6;
	localparam int CONCAT_BIT = 5;
	localparam int CB_OE_BIT = 4;
	localparam int GLOBAL_OE_BIT = 3;
	localparam int RX_OVR_BIT = 11;
	localparam int DEV_ADDR_MSB = 2;
	localparam int DEV_ADDR_LSB = 0;
	localparam logic [15:0] GOC_RESET = 16'h0000;
	localparam logic [15:0] GOC_MASK = 16'h087F;
	localparam logic [4:0] NULL_PHY_ADDR = 5'h1F;
	localparam int SYNC_STAGES = 3;
endpackage

// ===== src/gmoc_addr_match.sv
// Cell-bus address decoder for one direction: device match and channel select.
// Assumes addr comes from logic on ref_clk; result is registered.
`timescale 1ns/1ps
module gmoc_addr_match (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [2:0] dev_addr,
	input wire logic [4:0] bus_addr,
	output logic match,
	output logic [1:0] channel
);
	typedef struct packed {
		logic match;
		logic [1:0] channel;
	} gmoc_match_type;

	gmoc_match_type s_q;
	gmoc_match_type s_d;

	always_comb begin
		s_d = s_q;
		// Null address is never ours, even when the upper bits coincide
		s_d.match = (bus_addr != gmoc_pkg::NULL_PHY_ADDR) && (bus_addr[4:2] == dev_addr);
		s_d.channel = s_d.match ? bus_addr[1:0] : 2'h0;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign match = s_q.match;
	assign channel = s_q.channel;
endmodule // gmoc_addr_match

// ===== src/gmoc_global_config.sv
// Global operational configuration register: transceiver mode, concatenation,
// cell-bus and global output enables, and the cell-bus device address.
// Assumes an APB master on ref_clk; enable pins are asynchronous, cell-bus
// addresses arrive from logic on ref_clk.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module gmoc_global_config #(
	parameter int ADDR_W = 12
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cell_bus_output_enable_pin,
	input wire logic global_output_enable_pin,
	input wire logic [4:0] rx_cell_addr,
	input wire logic [4:0] tx_cell_addr,
	output logic quad_mode,
	output logic concat_mode,
	output logic cell_bus_oe,
	output logic rx_cell_bus_oe,
	output logic tx_cell_bus_oe,
	output logic global_oe,
	output logic rx_match,
	output logic [1:0] rx_channel,
	output logic tx_match,
	output logic [1:0] tx_channel
);
	typedef struct packed {
		logic [15:0] cfg;
		logic [gmoc_pkg::SYNC_STAGES-1:0] cb_sync;
		logic [gmoc_pkg::SYNC_STAGES-1:0] goe_sync;
		logic cb_pin;
		logic goe_pin;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic quad;
		logic concat;
		logic cb_oe;
		logic rx_oe;
		logic tx_oe;
		logic goe;
	} gmoc_state_type;

	gmoc_state_type s_q;
	gmoc_state_type s_d;
	logic hit;
	logic access;

	// The register offset needs four address bits; APB addresses stop at 32
	if (ADDR_W < 4 || ADDR_W > 32) begin : g_addr_w_check
		$error("ADDR_W must lie between 4 and 32");
	end

	assign hit = (paddr == ADDR_W'(gmoc_pkg::GOC_OFFSET));
	assign access = psel && penable;

	always_comb begin
		s_d = s_q;
		// Pins are asynchronous; a new level counts only once stages two and three agree
		s_d.cb_sync = {s_q.cb_sync[1:0], cell_bus_output_enable_pin};
		s_d.goe_sync = {s_q.goe_sync[1:0], global_output_enable_pin};
		if (s_q.cb_sync[2] == s_q.cb_sync[1]) begin
			s_d.cb_pin = s_q.cb_sync[2];
		end
		if (s_q.goe_sync[2] == s_q.goe_sync[1]) begin
			s_d.goe_pin = s_q.goe_sync[2];
		end
		// One wait state keeps pready and prdata straight from flops
		s_d.pready = access && !s_q.pready;
		s_d.pslverr = access && !s_q.pready && !hit;
		if (access && !s_q.pready) begin
			s_d.prdata = hit ? {16'h0000, s_q.cfg & gmoc_pkg::GOC_MASK} : 32'h0000_0000;
		end
		if (access && s_q.pready && pwrite && hit) begin
			s_d.cfg = pwdata[15:0] & gmoc_pkg::GOC_MASK;
		end
		s_d.quad = s_q.cfg[gmoc_pkg::QUAD_BIT];
		// Quad mode leaves the concatenation bit stored but without effect
		s_d.concat = !s_q.cfg[gmoc_pkg::QUAD_BIT] && s_q.cfg[gmoc_pkg::CONCAT_BIT];
		s_d.goe = s_q.cfg[gmoc_pkg::GLOBAL_OE_BIT] || s_q.goe_pin;
		s_d.cb_oe = s_q.cfg[gmoc_pkg::CB_OE_BIT] || s_q.cb_pin;
		// Global enable gates both cell-bus drive enables, receive and transmit; cell_bus_oe itself is not gated
		s_d.tx_oe = s_d.goe && s_d.cb_oe;
		s_d.rx_oe = s_d.goe && (s_d.cb_oe || s_q.cfg[gmoc_pkg::RX_OVR_BIT]);
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s_q <= '0;
			s_q.cfg <= gmoc_pkg::GOC_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	gmoc_addr_match u_rx_match (
		.ref_clk(ref_clk),
		.reset(reset),
		.dev_addr(s_q.cfg[gmoc_pkg::DEV_ADDR_MSB:gmoc_pkg::DEV_ADDR_LSB]),
		.bus_addr(rx_cell_addr),
		.match(rx_match),
		.channel(rx_channel)
	);

	gmoc_addr_match u_tx_match (
		.ref_clk(ref_clk),
		.reset(reset),
		.dev_addr(s_q.cfg[gmoc_pkg::DEV_ADDR_MSB:gmoc_pkg::DEV_ADDR_LSB]),
		.bus_addr(tx_cell_addr),
		.match(tx_match),
		.channel(tx_channel)
	);

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign quad_mode = s_q.quad;
	assign concat_mode = s_q.concat;
	assign cell_bus_oe = s_q.cb_oe;
	assign rx_cell_bus_oe = s_q.rx_oe;
	assign tx_cell_bus_oe = s_q.tx_oe;
	assign global_oe = s_q.goe;

	default clocking cb_main @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	// Mode outputs follow the stored bits one cycle later
	a_single_mode_out: assert property (!s_q.cfg[gmoc_pkg::QUAD_BIT] |=> !quad_mode)
		else $error("single mode not reflected");
	a_quad_mode_out: assert property (s_q.cfg[gmoc_pkg::QUAD_BIT] |=> quad_mode)
		else $error("quad mode not reflected");
	a_concat_quad_ignore: assert property (quad_mode |-> !concat_mode)
		else $error("concatenation active in quad mode");
	a_concat_single_sel: assert property (!s_q.cfg[gmoc_pkg::QUAD_BIT] |=> concat_mode == $past(s_q.cfg[5]))
		else $error("concatenation select not followed");

	// Enables: pin filter, OR with the register bit, then the gating
	a_cb_pin_filter: assert property (s_q.cb_sync[2] == s_q.cb_sync[1] |=> s_q.cb_pin == $past(s_q.cb_sync[2]))
		else $error("cell-bus pin level not taken");
	a_goe_pin_filter: assert property (s_q.goe_sync[2] == s_q.goe_sync[1] |=> s_q.goe_pin == $past(s_q.goe_sync[2]))
		else $error("global pin level not taken");
	a_cb_oe_or: assert property ((s_q.cfg[gmoc_pkg::CB_OE_BIT] || s_q.cb_pin) |=> cell_bus_oe)
		else $error("cell-bus enable OR broken");
	a_cb_oe_off: assert property (!(s_q.cfg[gmoc_pkg::CB_OE_BIT] || s_q.cb_pin) |=> !cell_bus_oe)
		else $error("cell-bus enable without cause");
	a_cb_hiz_off: assert property (!cell_bus_oe |-> !tx_cell_bus_oe)
		else $error("transmit cell bus driven while disabled");
	a_tx_drive_on: assert property (global_oe && cell_bus_oe |-> tx_cell_bus_oe)
		else $error("transmit cell bus not driven while enabled");
	a_goe_or: assert property (!(s_q.cfg[gmoc_pkg::GLOBAL_OE_BIT] || s_q.goe_pin) |=> !global_oe)
		else $error("global enable without cause");
	a_goe_or_on: assert property ((s_q.cfg[gmoc_pkg::GLOBAL_OE_BIT] || s_q.goe_pin) |=> global_oe)
		else $error("global enable OR broken");
	a_goe_gate_all: assert property (!global_oe |-> !rx_cell_bus_oe && !tx_cell_bus_oe)
		else $error("outputs driven while globally disabled");
	a_rx_override_on: assert property (s_q.cfg[gmoc_pkg::RX_OVR_BIT] && s_d.goe |=> rx_cell_bus_oe)
		else $error("receive override ignored");
	a_rx_override_off: assert property (!s_q.cfg[gmoc_pkg::RX_OVR_BIT] && !s_d.cb_oe |=> !rx_cell_bus_oe)
		else $error("receive cell bus driven while disabled");

	// Cell-bus decode, both directions
	a_null_no_answer: assert property (rx_cell_addr == gmoc_pkg::NULL_PHY_ADDR |=> !rx_match)
		else $error("null address answered");
	a_tx_null_no_answer: assert property (tx_cell_addr == gmoc_pkg::NULL_PHY_ADDR |=> !tx_match)
		else $error("null transmit address answered");
	a_rx_addr_match: assert property (rx_cell_addr != 5'h1F && rx_cell_addr[4:2] == s_q.cfg[2:0] |=> rx_match)
		else $error("receive address match missed");
	a_rx_no_match: assert property (rx_cell_addr[4:2] != s_q.cfg[2:0] |=> !rx_match && rx_channel == 2'h0)
		else $error("foreign receive address answered");
	a_rx_chan_sel: assert property (rx_cell_addr != 5'h1F && rx_cell_addr[4:2] == s_q.cfg[2:0]
		|=> rx_channel == $past(rx_cell_addr[1:0]))
		else $error("receive channel select wrong");
	a_tx_chan_sel: assert property (tx_cell_addr != 5'h1F && tx_cell_addr[4:2] == s_q.cfg[2:0]
		|=> tx_match && tx_channel == $past(tx_cell_addr[1:0]))
		else $error("transmit channel select wrong");

	// Register access
	a_write_lands: assert property (access && pready && pwrite && hit
		|=> s_q.cfg == ($past(pwdata[15:0]) & gmoc_pkg::GOC_MASK))
		else $error("register write not stored");
	a_read_back: assert property (access && !pready && !pwrite && hit
		|=> pready && !pslverr && prdata == {16'h0000, $past(s_q.cfg)})
		else $error("register read-back mismatch");
	a_unmapped_err: assert property (access && !pready && !hit |=> pready && pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
	a_unmapped_keep: assert property (access && pready && !hit |=> s_q.cfg == $past(s_q.cfg))
		else $error("unmapped write changed the register");
	a_pready_spacing: assert property (pready |=> !pready)
		else $error("pready held for two cycles");
	a_pready_only_access: assert property (!access |=> !pready)
		else $error("pready without an access");

	// Reset is checked on its own, so it carries its own empty disable
	a_reset_defaults: assert property (@(posedge ref_clk) disable iff (1'b0) reset
		|=> s_q.cfg == gmoc_pkg::GOC_RESET && !quad_mode && !global_oe && !pready && !rx_match)
		else $error("reset did not restore defaults");

	c_quad_mode: cover property (quad_mode);
	c_concat_single: cover property (concat_mode);
	c_rx_match_chan3: cover property (rx_match && rx_channel == 2'h3);
	c_unmapped_access: cover property (pslverr);
	c_rx_override: cover property (rx_cell_bus_oe && !cell_bus_oe);
endmodule // gmoc_global_config

// ===== tb/gmoc_atm_layer.sv
// Model of the ATM layer device polling PHY ports over the cell bus.
// Assumes it runs on ref_clk; addresses change only after a rising edge.
`timescale 1ns/1ps
module gmoc_atm_layer (
	input wire logic ref_clk,
	input wire logic poll,
	input wire logic [4:0] rx_want,
	input wire logic [4:0] tx_want,
	output logic [4:0] rx_cell_addr,
	output logic [4:0] tx_cell_addr
);
	// Idle polling parks on the null address so no port may answer
	always_ff @(posedge ref_clk) begin
		rx_cell_addr <= poll ? rx_want : gmoc_pkg::NULL_PHY_ADDR;
		tx_cell_addr <= poll ? tx_want : gmoc_pkg::NULL_PHY_ADDR;
	end
endmodule // gmoc_atm_layer

// ===== tb/testbench.sv
// Self-checking bench for the global mode and output-enable register.
// Assumes an APB slave with one wait state and registered derived outputs.
`timescale 1ns/1ps
module testbench;
	logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, poll;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic cp, gp, quad_mode, concat_mode, cell_bus_oe, rx_cell_bus_oe, tx_cell_bus_oe, global_oe;
	logic rx_match, tx_match;
	logic [1:0] rx_channel, tx_channel;
	logic [4:0] rx_want, tx_want, rx_cell_addr, tx_cell_addr;
	int num_errors, cmp_count;
	gmoc_global_config uut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cell_bus_output_enable_pin(cp), .global_output_enable_pin(gp), .rx_cell_addr(rx_cell_addr),
		.tx_cell_addr(tx_cell_addr), .quad_mode(quad_mode), .concat_mode(concat_mode),
		.cell_bus_oe(cell_bus_oe), .rx_cell_bus_oe(rx_cell_bus_oe), .tx_cell_bus_oe(tx_cell_bus_oe),
		.global_oe(global_oe), .rx_match(rx_match), .rx_channel(rx_channel), .tx_match(tx_match),
		.tx_channel(tx_channel));
	gmoc_atm_layer far (.ref_clk(ref_clk), .poll(poll), .rx_want(rx_want), .tx_want(tx_want),
		.rx_cell_addr(rx_cell_addr), .tx_cell_addr(tx_cell_addr));
	initial begin
		ref_clk = 0;
		forever #5 ref_clk = ~ref_clk;
	end
	task finish_test;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge ref_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			num_errors++;
			finish_test();
		end
	endtask
	// Address match as seen from the cell bus; null address never answers
	function automatic logic [2:0] exp_dec(input logic [4:0] a, input logic [2:0] base);
		logic m;
		m = (a != 5'h1F) && (a[4:2] == base);
		return {m, m ? a[1:0] : 2'b00};
	endfunction
	logic [31:0] r, v;
	logic e, g, c;
	logic [12:0] s;
	initial begin
		num_errors = 0;
		cmp_count = 0;
		{reset, psel, penable, pwrite, paddr, pwdata, cp, gp, poll, rx_want, tx_want} = '0;
		reset = 1'b1;
		r = $urandom(32'h4b8f723a);
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		apb(1'b0, gmoc_pkg::GOC_OFFSET, 32'h0, r, e);
		chk(r, gmoc_pkg::GOC_RESET);
		chk(e, 1'b0);
		apb(1'b1, 12'h00C, 32'hFFFF, r, e);
		chk(e, 1'b1);
		apb(1'b0, 12'h00C, 32'h0, r, e);
		chk(e, 1'b1);
		chk(r, 32'h0000_0000);
		for (int i = 0; i < 32; i++) begin
			v = (i == 0) ? 32'hFFFF : (i == 1) ? 32'h0 : $urandom;
			v[5] = v[5] | v[6];
			// Top base meets the null address on the transmit side
			if (i == 9) v[2:0] = 3'h7;
			// Address and mode go in before any enable, avoiding bus fights
			apb(1'b1, gmoc_pkg::GOC_OFFSET, v & 32'hFFE7, r, e);
			apb(1'b1, gmoc_pkg::GOC_OFFSET, v, r, e);
			// Pins, polling and addresses are composed first so each gets one assignment
			s = 13'($urandom);
			if (i % 2) s[10:5] = {1'b1, v[2:0], i[2:1]};
			if (i % 4 == 1) s[4:0] = (i % 8 == 1) ? 5'h1F : {v[2:0], 2'b11};
			{cp, gp, poll, rx_want, tx_want} <= s;
			repeat (8) @(posedge ref_clk);
			apb(1'b0, gmoc_pkg::GOC_OFFSET, 32'h0, r, e);
			chk(r, v & {16'h0, gmoc_pkg::GOC_MASK});
			c = v[4] | cp;
			g = v[3] | gp;
			chk(quad_mode, v[6]);
			chk(concat_mode, !v[6] & v[5]);
			chk(cell_bus_oe, c);
			chk(global_oe, g);
			chk(tx_cell_bus_oe, g & c);
			chk(rx_cell_bus_oe, g & (c | v[11]));
			chk({rx_match, rx_channel}, exp_dec(poll ? rx_want : 5'h1F, v[2:0]));
			chk({tx_match, tx_channel}, exp_dec(poll ? tx_want : 5'h1F, v[2:0]));
		end
		// Mid-run reset must bring every field back to its default
		{cp, gp} <= 2'b00;
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		apb(1'b0, gmoc_pkg::GOC_OFFSET, 32'h0, r, e);
		chk(r, {16'h0000, gmoc_pkg::GOC_RESET});
		chk({quad_mode, concat_mode, global_oe, tx_cell_bus_oe}, 4'h0);
		finish_test();
	end
endmodule // testbench
